/* core/sdc_regs.svh */
// register map, field positions and reset values of the sdram control block
// assumes a 32-bit apb with full byte addresses on paddr
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

`define SDC_CTRL_ADDR 32'h1301_0080
`define SDC_RTCS_ADDR 32'h1301_0084
`define SDC_REFRESH_COUNTER_ADDR 32'h1301_0088
`define SDC_REFRESH_CONSTANT_ADDR 32'h1301_008c
`define SDC_BANK_ADDR 32'h1301_0090
`define SDC_MODE_BASE 32'h1301_a000
`define SDC_MODE_MASK 32'hffff_fc00

`define SDC_CTRL_RST 32'h0000_0000
`define SDC_BANK_RST 32'h0000_20f8
`define SDC_HALF_RST 16'h0000
`define SDC_CTRL_WMASK 32'h9fbe_ff7f

`define SDC_F_BUS16 31
`define SDC_F_COL_HI 28
`define SDC_F_COL_LO 26
`define SDC_F_RTYPE 25
`define SDC_F_RFEN 24
`define SDC_F_MODESEL 23
`define SDC_F_ROW_HI 21
`define SDC_F_ROW_LO 20
`define SDC_F_BANK 19
`define SDC_F_APD 18
`define SDC_F_CKE 17

`define SDC_MODE_W 10

`endif

/* core/sdc_pkg.sv */
// types shared by the sdram control block
// no dependencies
package sdc_pkg;

   typedef enum logic [2:0]
   {
      SDC_CMD_NOP = 3'h0,
      SDC_CMD_PALL = 3'h1,
      SDC_CMD_MRS = 3'h2,
      SDC_CMD_PDEN = 3'h3,
      SDC_CMD_PDEX = 3'h4
   } sdc_cmd_e_t;

   // gray codes along active -> auto power-down and active -> sw power-down
   typedef enum logic [1:0]
   {
      SDC_ST_ACTIVE = 2'h0,
      SDC_ST_AUTO_PD = 2'h1,
      SDC_ST_SW_PD = 2'h2
   } sdc_state_t;

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } sdc_apb_req_t;

   typedef struct packed
   {
      sdc_cmd_e_t cmd;
      logic [9:0] addr;
   } sdc_cmd_t;

endpackage : sdc_pkg

/* core/sdc_width_decode.sv */
// registered decode of the geometry and refresh fields of the control word
// assumes i_ctrl comes from a flip-flop on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "sdc_regs.svh"
module sdc_width_decode
(
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   // control word
   input wire logic [31:0] i_ctrl,
   // decoded geometry
   output logic o_bus16,
   output logic [3:0] o_col_bits,
   output logic [3:0] o_row_bits,
   output logic [1:0] o_bank_bits,
   output logic o_refresh_en,
   output logic o_self_refresh,
   output logic o_cfg_reserved
);
   logic [2:0] col;
   logic [1:0] row;
   logic [12:0] dec_next;
   logic [12:0] dec_reg;

   always_comb
   begin
      col = i_ctrl[`SDC_F_COL_HI:`SDC_F_COL_LO];
      row = i_ctrl[`SDC_F_ROW_HI:`SDC_F_ROW_LO];
      dec_next[0] = i_ctrl[`SDC_F_BUS16];
      // reserved codes report zero width and raise the flag
      dec_next[4:1] = (col > 3'h4) ? 4'h0 : 4'h8 + {1'b0, col};
      dec_next[8:5] = (row == 2'h3) ? 4'h0 : 4'hb + {2'h0, row};
      dec_next[10:9] = i_ctrl[`SDC_F_BANK] ? 2'h2 : 2'h1;
      dec_next[11] = i_ctrl[`SDC_F_RFEN];
      dec_next[12] = i_ctrl[`SDC_F_RTYPE];
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         dec_reg <= 13'h0370;
      else if (i_ce)
         dec_reg <= dec_next;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         o_cfg_reserved <= 1'b0;
      else if (i_ce)
         o_cfg_reserved <= (dec_next[4:1] == 4'h0) || (dec_next[8:5] == 4'h0);
   end

   assign o_bus16 = dec_reg[0];
   assign o_col_bits = dec_reg[4:1];
   assign o_row_bits = dec_reg[8:5];
   assign o_bank_bits = dec_reg[10:9];
   assign o_refresh_en = dec_reg[11];
   assign o_self_refresh = dec_reg[12];
endmodule : sdc_width_decode
`default_nettype wire

/* core/sdc_cmd_out.sv */
// output register for sdram commands and the mode value on the address bus
// assumes i_valid is a one-cycle request on the same clock
`timescale 1ns/1ps
`default_nettype none
module sdc_cmd_out
(
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   // request
   input wire logic i_valid,
   input wire sdc_pkg::sdc_cmd_t i_cmd,
   // to the pins
   output sdc_pkg::sdc_cmd_t o_cmd
);
   sdc_pkg::sdc_cmd_t cmd_next;

   // address is held after the command so the pins do not toggle needlessly
   always_comb
   begin
      cmd_next.cmd = sdc_pkg::SDC_CMD_NOP;
      cmd_next.addr = o_cmd.addr;
      if (i_valid)
         cmd_next = i_cmd;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         o_cmd <= '{sdc_pkg::SDC_CMD_NOP, 10'h000};
      else if (i_ce)
         o_cmd <= cmd_next;
   end
endmodule : sdc_cmd_out
`default_nettype wire

/* core/sdc_ctrl.sv */
// sdram control and configuration block: apb register file, mode writes,
// clock-enable and power-down control
// assumes access/refresh busy levels come from the memory engine on i_clk
//
// Overview of operation
// - any reset clears control register to zero
// - bit 31 picks 32-bit or 16-bit bus
// - bits 28:26 give column width 8..12
// - reserved bits 30:29, 22 read zero
// - bit 25 refresh type, bit 24 enable
// - mode write issues precharge-all or mode-set
// - bits 21:20 give row width 11..13
// - bit 19 selects two or four banks
// - bit 18 powers down and stops idle clock while bit 17 is set
// - bit 17 drives clock enable; clear powers down when the external clock output is enabled
// - after software power-down only exit is allowed
// - mode register is write-only, reads unsupported
// - mode value is the written address offset
// - setting bit 17 issues power-down exit
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sdc_regs.svh"
module sdc_ctrl
(
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   // apb slave
   input wire sdc_pkg::sdc_apb_req_t i_apb,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   // memory engine and clock unit
   input wire logic i_access_busy,
   input wire logic i_refresh_busy,
   input wire logic i_ext_clock_out_enable,
   // sdram side
   output sdc_pkg::sdc_cmd_t o_cmd,
   output logic o_cke,
   output logic o_cko_run,
   // decoded configuration
   output logic o_bus16,
   output logic [3:0] o_col_bits,
   output logic [3:0] o_row_bits,
   output logic [1:0] o_bank_bits,
   output logic o_refresh_en,
   output logic o_self_refresh,
   output logic o_cfg_reserved
);
   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic [15:0] rtcs_reg;
   logic [15:0] rtcs_next;
   logic [15:0] refresh_counter_reg;
   logic [15:0] refresh_counter_next;
   logic [15:0] refresh_constant_reg;
   logic [15:0] refresh_constant_next;
   logic [31:0] bank_reg;
   logic [31:0] bank_next;
   logic pready_next;
   logic [31:0] prdata_next;
   logic pslverr_next;
   sdc_pkg::sdc_state_t st_reg;
   sdc_pkg::sdc_state_t st_next;
   logic cke_next;
   logic cko_next;
   logic cmd_valid;
   sdc_pkg::sdc_cmd_t cmd_req;
   logic setup;
   logic wr;
   logic mode_hit;
   logic mapped;
   logic busy;

   always_comb
   begin
      setup = i_apb.psel && !i_apb.penable;
      wr = i_apb.psel && i_apb.penable && o_pready && i_apb.pwrite && !o_pslverr;
      mode_hit = (i_apb.paddr & `SDC_MODE_MASK) == `SDC_MODE_BASE;
      busy = i_access_busy || i_refresh_busy;
      mapped = mode_hit;
      case (i_apb.paddr)
         `SDC_CTRL_ADDR, `SDC_RTCS_ADDR, `SDC_REFRESH_COUNTER_ADDR,
         `SDC_REFRESH_CONSTANT_ADDR, `SDC_BANK_ADDR:
            mapped = 1'b1;
         default:
            mapped = mode_hit;
      endcase
   end

   // apb answer: registered one cycle after setup, so access is one cycle
   always_comb
   begin
      pready_next = setup;
      pslverr_next = setup && (!mapped || (mode_hit && !i_apb.pwrite));
      prdata_next = 32'h0000_0000;
      if (setup && !i_apb.pwrite)
      begin
         case (i_apb.paddr)
            `SDC_CTRL_ADDR:
               prdata_next = ctrl_reg & `SDC_CTRL_WMASK;
            `SDC_RTCS_ADDR:
               prdata_next = {16'h0000, rtcs_reg};
            `SDC_REFRESH_COUNTER_ADDR:
               prdata_next = {16'h0000, refresh_counter_reg};
            `SDC_REFRESH_CONSTANT_ADDR:
               prdata_next = {16'h0000, refresh_constant_reg};
            `SDC_BANK_ADDR:
               prdata_next = bank_reg;
            default:
               prdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0000_0000;
      end
      else if (i_ce)
      begin
         o_pready <= pready_next;
         o_pslverr <= pslverr_next;
         o_prdata <= prdata_next;
      end
   end

   // register writes, power state and sdram commands
   always_comb
   begin
      ctrl_next = ctrl_reg;
      rtcs_next = rtcs_reg;
      refresh_counter_next = refresh_counter_reg;
      refresh_constant_next = refresh_constant_reg;
      bank_next = bank_reg;
      st_next = st_reg;
      cmd_valid = 1'b0;
      // power commands keep the last mode value on the address pins
      cmd_req = '{sdc_pkg::SDC_CMD_NOP, o_cmd.addr};
      if (wr)
      begin
         case (i_apb.paddr)
            `SDC_CTRL_ADDR:
               ctrl_next = i_apb.pwdata & `SDC_CTRL_WMASK;
            `SDC_RTCS_ADDR:
               rtcs_next = i_apb.pwdata[15:0];
            `SDC_REFRESH_COUNTER_ADDR:
               refresh_counter_next = i_apb.pwdata[15:0];
            `SDC_REFRESH_CONSTANT_ADDR:
               refresh_constant_next = i_apb.pwdata[15:0];
            `SDC_BANK_ADDR:
               bank_next = i_apb.pwdata;
            default:
               bank_next = bank_reg;
         endcase
      end
      // a mode write while powered down by software is dropped, not queued
      if (wr && mode_hit && st_reg != sdc_pkg::SDC_ST_SW_PD)
      begin
         cmd_valid = 1'b1;
         cmd_req.cmd = ctrl_reg[`SDC_F_MODESEL] ? sdc_pkg::SDC_CMD_MRS : sdc_pkg::SDC_CMD_PALL;
         cmd_req.addr = i_apb.paddr[`SDC_MODE_W-1:0];
      end
      if (ctrl_reg[`SDC_F_CKE] && !ctrl_next[`SDC_F_CKE] && i_ext_clock_out_enable)
      begin
         cmd_valid = 1'b1;
         cmd_req.cmd = sdc_pkg::SDC_CMD_PDEN;
         st_next = sdc_pkg::SDC_ST_SW_PD;
      end
      else if (!ctrl_reg[`SDC_F_CKE] && ctrl_next[`SDC_F_CKE])
      begin
         cmd_valid = 1'b1;
         cmd_req.cmd = sdc_pkg::SDC_CMD_PDEX;
         st_next = sdc_pkg::SDC_ST_ACTIVE;
      end
      else
      begin
         case (st_reg)
            sdc_pkg::SDC_ST_ACTIVE:
               if (ctrl_reg[`SDC_F_APD] && ctrl_reg[`SDC_F_CKE] && !busy)
                  st_next = sdc_pkg::SDC_ST_AUTO_PD;
            sdc_pkg::SDC_ST_AUTO_PD:
               if (busy || !ctrl_reg[`SDC_F_APD] || !ctrl_reg[`SDC_F_CKE])
                  st_next = sdc_pkg::SDC_ST_ACTIVE;
            sdc_pkg::SDC_ST_SW_PD:
               st_next = sdc_pkg::SDC_ST_SW_PD;
            default:
               st_next = sdc_pkg::SDC_ST_ACTIVE;
         endcase
      end
      cke_next = ctrl_next[`SDC_F_CKE] && st_next == sdc_pkg::SDC_ST_ACTIVE;
      cko_next = st_next != sdc_pkg::SDC_ST_AUTO_PD;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         ctrl_reg <= `SDC_CTRL_RST;
         rtcs_reg <= `SDC_HALF_RST;
         refresh_counter_reg <= `SDC_HALF_RST;
         refresh_constant_reg <= `SDC_HALF_RST;
         bank_reg <= `SDC_BANK_RST;
         st_reg <= sdc_pkg::SDC_ST_ACTIVE;
         o_cke <= 1'b0;
         o_cko_run <= 1'b1;
      end
      else if (i_ce)
      begin
         ctrl_reg <= ctrl_next;
         rtcs_reg <= rtcs_next;
         refresh_counter_reg <= refresh_counter_next;
         refresh_constant_reg <= refresh_constant_next;
         bank_reg <= bank_next;
         st_reg <= st_next;
         o_cke <= cke_next;
         o_cko_run <= cko_next;
      end
   end

   sdc_cmd_out u_cmd_out
   (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_valid(cmd_valid),
      .i_cmd(cmd_req),
      .o_cmd(o_cmd)
   );

   sdc_width_decode u_decode
   (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_ctrl(ctrl_reg),
      .o_bus16(o_bus16),
      .o_col_bits(o_col_bits),
      .o_row_bits(o_row_bits),
      .o_bank_bits(o_bank_bits),
      .o_refresh_en(o_refresh_en),
      .o_self_refresh(o_self_refresh),
      .o_cfg_reserved(o_cfg_reserved)
   );

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   property p_reset_clear;
      @(posedge i_clk) disable iff (1'b0) i_srst |=> ctrl_reg == 32'h0000_0000 && !o_cke;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("control not cleared by reset");

   property p_bus16;
      i_ce && !i_srst ##1 i_ce |-> o_bus16 == $past(ctrl_reg[31]);
   endproperty
   a_bus16: assert property (p_bus16) else $error("bus width decode wrong");

   property p_col;
      i_ce && ctrl_reg[28:26] == 3'h2 |=> o_col_bits == 4'ha;
   endproperty
   a_col: assert property (p_col) else $error("column width decode wrong");

   property p_resv_read;
      setup && !i_apb.pwrite && i_apb.paddr == `SDC_CTRL_ADDR && i_ce
      |=> o_prdata[30:29] == 2'h0 && !o_prdata[22] && o_pready;
   endproperty
   a_resv_read: assert property (p_resv_read) else $error("reserved bits read nonzero");

   property p_row;
      i_ce && ctrl_reg[21:20] == 2'h2 |=> o_row_bits == 4'hd;
   endproperty
   a_row: assert property (p_row) else $error("row width decode wrong");

   property p_mode_cmd;
      i_ce && wr && mode_hit && st_reg != sdc_pkg::SDC_ST_SW_PD
      |=> o_cmd.addr == $past(i_apb.paddr[9:0])
          && o_cmd.cmd == ($past(ctrl_reg[23]) ? sdc_pkg::SDC_CMD_MRS : sdc_pkg::SDC_CMD_PALL);
   endproperty
   a_mode_cmd: assert property (p_mode_cmd) else $error("mode write command wrong");

   property p_auto_pd;
      st_reg == sdc_pkg::SDC_ST_AUTO_PD && $past(i_ce)
      |-> !o_cke && !o_cko_run && !$past(busy) && $past(ctrl_reg[18]);
   endproperty
   a_auto_pd: assert property (p_auto_pd) else $error("auto power-down wrong");

   property p_pd_enter;
      i_ce && wr && i_apb.paddr == `SDC_CTRL_ADDR && ctrl_reg[17] && !i_apb.pwdata[17]
      && i_ext_clock_out_enable |=> o_cmd.cmd == sdc_pkg::SDC_CMD_PDEN && !o_cke;
   endproperty
   a_pd_enter: assert property (p_pd_enter) else $error("power-down entry missing");

   property p_pd_lock;
      st_reg == sdc_pkg::SDC_ST_SW_PD && $past(st_reg) == sdc_pkg::SDC_ST_SW_PD && $past(i_ce)
      |-> o_cmd.cmd == sdc_pkg::SDC_CMD_NOP || o_cmd.cmd == sdc_pkg::SDC_CMD_PDEX;
   endproperty
   a_pd_lock: assert property (p_pd_lock) else $error("command issued in power-down");

   property p_mode_read;
      setup && mode_hit && !i_apb.pwrite && i_ce |=> o_pslverr && o_pready && o_prdata == 32'h0;
   endproperty
   a_mode_read: assert property (p_mode_read) else $error("mode read not refused");

   property p_pd_exit;
      i_ce && wr && i_apb.paddr == `SDC_CTRL_ADDR && !ctrl_reg[17] && i_apb.pwdata[17]
      |=> o_cmd.cmd == sdc_pkg::SDC_CMD_PDEX ##1 (!i_ce || o_cke || busy || ctrl_reg[18]);
   endproperty
   a_pd_exit: assert property (p_pd_exit) else $error("power-down exit missing");

   c_mrs: cover property (o_cmd.cmd == sdc_pkg::SDC_CMD_MRS);
   c_auto_pd: cover property (st_reg == sdc_pkg::SDC_ST_AUTO_PD ##1 st_reg == sdc_pkg::SDC_ST_ACTIVE);
   c_sw_pd: cover property (o_cmd.cmd == sdc_pkg::SDC_CMD_PDEN ##[1:50] o_cmd.cmd == sdc_pkg::SDC_CMD_PDEX);
endmodule : sdc_ctrl
`default_nettype wire

/* tb/sdc_sdram_model.sv */
// partner model of the external sdram chip: follows commands and power-down
// assumes one-cycle commands from sdc_ctrl on the same clock
`timescale 1ns/1ps
`default_nettype none
module sdc_sdram_model
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // controller pins
   input wire sdc_pkg::sdc_cmd_t i_cmd,
   input wire logic i_cke,
   // observed chip state
   output logic [9:0] o_mode_reg,
   output logic o_pd,
   output logic [7:0] o_bad_cmds
);
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_mode_reg <= 10'h000;
         o_pd <= 1'b0;
         o_bad_cmds <= 8'h00;
      end
      else
      begin
         // a powered-down chip only understands the exit command
         if (o_pd && i_cmd.cmd != sdc_pkg::SDC_CMD_NOP && i_cmd.cmd != sdc_pkg::SDC_CMD_PDEX)
            o_bad_cmds <= o_bad_cmds + 8'h01;
         if (i_cmd.cmd == sdc_pkg::SDC_CMD_MRS)
            o_mode_reg <= i_cmd.addr;
         if (i_cmd.cmd == sdc_pkg::SDC_CMD_PDEN && !i_cke)
            o_pd <= 1'b1;
         else if (i_cmd.cmd == sdc_pkg::SDC_CMD_PDEX)
            o_pd <= 1'b0;
      end
   end
endmodule : sdc_sdram_model
`default_nettype wire

/* tb/sdc_ctrl_tb_top.sv */
// self-checking bench of sdc_ctrl: apb register tests, mode writes, power control
// assumes the sdram model and the design package are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "sdc_regs.svh"
module sdc_ctrl_tb_top;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_ce = 1'b1;
   sdc_pkg::sdc_apb_req_t apb = '0;
   logic acc_busy = 1'b0;
   logic rfr_busy = 1'b0;
   logic cko_en = 1'b0;
   logic pready, pslverr, bus16, rf_en, self_rf, cfg_res, cke, cko_run, chip_pd, err;
   logic [31:0] prdata, rd;
   logic [3:0] col_bits, row_bits;
   logic [1:0] bank_bits;
   logic [9:0] mode_reg;
   logic [7:0] bad_cmds;
   sdc_pkg::sdc_cmd_t cmd;
   int fail_count = 0;
   int cmp_count = 0;

   always #50 i_clk = ~i_clk;

   sdc_ctrl dut (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_apb(apb), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(pslverr), .i_access_busy(acc_busy), .i_refresh_busy(rfr_busy),
      .i_ext_clock_out_enable(cko_en), .o_cmd(cmd), .o_cke(cke), .o_cko_run(cko_run),
      .o_bus16(bus16), .o_col_bits(col_bits), .o_row_bits(row_bits), .o_bank_bits(bank_bits),
      .o_refresh_en(rf_en), .o_self_refresh(self_rf), .o_cfg_reserved(cfg_res));

   sdc_sdram_model chip (.i_clk(i_clk), .i_srst(i_srst), .i_cmd(cmd), .i_cke(cke),
      .o_mode_reg(mode_reg), .o_pd(chip_pd), .o_bad_cmds(bad_cmds));

   task close_out;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // one apb transfer; the request is held until pready is sampled high
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clk);
      apb <= '{1'b1, 1'b0, w, a, d};
      @(posedge i_clk);
      apb.penable <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge i_clk);
         if (pready === 1'b1)
            break;
      end
      if (n == 20)
      begin
         fail_count++;
         close_out();
      end
      else
      begin
         rd = prdata;
         err = pslverr;
         apb.psel <= 1'b0;
         apb.penable <= 1'b0;
      end
   endtask : xfer

   task wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(name, rd, exp);
      check("pslverr", 32'(err), 32'h0);
   endtask : rdchk

   // command is looked at in the one cycle that it stands
   task cmd_is(input sdc_pkg::sdc_cmd_e_t c, input logic [9:0] a, input logic k);
      #1;
      check("cmd", 32'(cmd), 32'({c, a}));
      check("cke", 32'(cke), 32'(k));
   endtask : cmd_is

   initial
   begin
      repeat (8) @(posedge i_clk);
      i_srst <= 1'b0;
      #1;
      check("col", 32'(col_bits), 32'h8);
      check("row", 32'(row_bits), 32'hb);
      check("bank", 32'(bank_bits), 32'h1);
      rdchk("ctrl", `SDC_CTRL_ADDR, 32'h0);
      rdchk("bank", `SDC_BANK_ADDR, 32'h0000_20f8);
      rdchk("refresh_counter", `SDC_REFRESH_COUNTER_ADDR, 32'h0);
      check("cke", 32'(cke), 32'h0);
      $display("test reset done");
      wr(`SDC_CTRL_ADDR, 32'hffff_ffff);
      rdchk("ctrl", `SDC_CTRL_ADDR, 32'h9fbe_ff7f);
      repeat (2) @(posedge i_clk);
      #1;
      check("col", 32'(col_bits), 32'h0);
      check("row", 32'(row_bits), 32'h0);
      check("rsv", 32'(cfg_res), 32'h1);
      wr(`SDC_REFRESH_COUNTER_ADDR, 32'hffff_ffff);
      rdchk("refresh_counter", `SDC_REFRESH_COUNTER_ADDR, 32'h0000_ffff);
      $display("test reserved done");
      for (int i = 0; i < 5; i++)
      begin
         wr(`SDC_CTRL_ADDR, {i[0], 2'h0, i[2:0], i[1], i[0], 2'h0, 2'(i % 3), ~i[0], 19'h0});
         repeat (2) @(posedge i_clk);
         #1;
         check("bus16", 32'(bus16), 32'(i[0]));
         check("col", 32'(col_bits), 32'(8 + i));
         check("row", 32'(row_bits), 32'(11 + i % 3));
         check("bank", 32'(bank_bits), i[0] ? 32'h1 : 32'h2);
         check("rfen", 32'(rf_en), 32'(i[0]));
         check("self", 32'(self_rf), 32'(i[1]));
         check("rsv", 32'(cfg_res), 32'h0);
      end
      $display("test geometry done");
      // the mode window takes a precharge-all and a mode-set write; a read there must be refused
      wr(`SDC_MODE_BASE + 32'h3ff, 32'h1234_5678);
      cmd_is(sdc_pkg::SDC_CMD_PALL, 10'h3ff, 1'b0);
      wr(`SDC_CTRL_ADDR, 32'h0080_0000);
      wr(`SDC_MODE_BASE + 32'h022, 32'hffff_ffff);
      cmd_is(sdc_pkg::SDC_CMD_MRS, 10'h022, 1'b0);
      @(posedge i_clk);
      cmd_is(sdc_pkg::SDC_CMD_NOP, 10'h022, 1'b0);
      check("mode", 32'(mode_reg), 32'h022);
      xfer(1'b0, `SDC_MODE_BASE + 32'h004, 32'h0);
      check("mode rd err", 32'(err), 32'h1);
      check("mode rd data", rd, 32'h0);
      xfer(1'b0, 32'h1301_0094, 32'h0);
      check("unmapped err", 32'(err), 32'h1);
      $display("test mode done");
      @(posedge i_clk);
      cko_en <= 1'b1;
      wr(`SDC_CTRL_ADDR, 32'h0082_0000);
      cmd_is(sdc_pkg::SDC_CMD_PDEX, 10'h022, 1'b1);
      wr(`SDC_CTRL_ADDR, 32'h0080_0000);
      cmd_is(sdc_pkg::SDC_CMD_PDEN, 10'h022, 1'b0);
      wr(`SDC_MODE_BASE + 32'h001, 32'h0);
      cmd_is(sdc_pkg::SDC_CMD_NOP, 10'h022, 1'b0);
      check("chip pd", 32'(chip_pd), 32'h1);
      wr(`SDC_CTRL_ADDR, 32'h0082_0000);
      cmd_is(sdc_pkg::SDC_CMD_PDEX, 10'h022, 1'b1);
      wr(`SDC_MODE_BASE + 32'h001, 32'h0);
      cmd_is(sdc_pkg::SDC_CMD_MRS, 10'h001, 1'b1);
      @(posedge i_clk);
      #1;
      check("chip bad cmds", 32'(bad_cmds), 32'h0);
      check("chip pd", 32'(chip_pd), 32'h0);
      $display("test power-down done");
      wr(`SDC_CTRL_ADDR, 32'h0086_0000);
      for (int k = 0; k < 2; k++)
      begin
         repeat (3) @(posedge i_clk);
         #1;
         check("auto cke", 32'(cke), 32'h0);
         check("auto cko", 32'(cko_run), 32'h0);
         @(posedge i_clk);
         {rfr_busy, acc_busy} <= 2'(k + 1);
         repeat (2) @(posedge i_clk);
         #1;
         check("busy cke", 32'(cke), 32'h1);
         check("busy cko", 32'(cko_run), 32'h1);
         @(posedge i_clk);
         {rfr_busy, acc_busy} <= 2'h0;
      end
      // clock enable low must freeze the power state although busy rises
      repeat (3) @(posedge i_clk);
      i_ce <= 1'b0;
      acc_busy <= 1'b1;
      repeat (3) @(posedge i_clk);
      #1;
      check("frozen cke", 32'(cke), 32'h0);
      check("frozen cko", 32'(cko_run), 32'h0);
      @(posedge i_clk);
      i_ce <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1;
      check("thawed cke", 32'(cke), 32'h1);
      @(posedge i_clk);
      acc_busy <= 1'b0;
      $display("test auto power-down done");
      @(posedge i_clk);
      i_srst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_srst <= 1'b0;
      rdchk("ctrl", `SDC_CTRL_ADDR, 32'h0);
      check("cke", 32'(cke), 32'h0);
      check("cko", 32'(cko_run), 32'h1);
      $display("test second reset done");
      close_out();
   end
endmodule : sdc_ctrl_tb_top
`default_nettype wire
